// >>> hdl/dbc_bank_control.sv
// Bank decode, strobe sequencing and refresh for the DRAM array
`timescale 1ns/10ps
`default_nettype none

module dbc_bank_control #(
   parameter int NUM_BANKS      = dbc_pkg::MAX_BANKS,
   parameter int REFRESH_CYC    = dbc_pkg::REFRESH_CYC,
   parameter int RAS_MAX_CYC    = dbc_pkg::RAS_MAX_CYC,
   parameter bit USE_EXT_TICK   = 1'b0,
   parameter int EXT_TICK_COUNT = dbc_pkg::EXT_TICK_COUNT
) (
   input  wire logic                                 sys_clk,
   input  wire logic                                 sys_rst,
   input  wire logic [dbc_pkg::BUS_W-1:0]            busAd,
   input  wire logic                                 addrLatch,
   input  wire logic                                 busRead,
   input  wire logic                                 busWrite,
   input  wire logic                                 writeNear,
   input  wire logic [dbc_pkg::NUM_LANES-1:0]        byteEnable,
   input  wire logic                                 extRefreshTick,
   output logic      [dbc_pkg::MAX_BANKS-1:0]        rowStrobeBankN,
   output logic      [dbc_pkg::MAX_BANKS-1:0]        bankWriteStrobeN,
   output logic      [dbc_pkg::NUM_LANES-1:0]        columnStrobeLaneN,
   output logic      [dbc_pkg::DEV_ADDR_W-1:0]       memAddr,
   output logic                                      busAck,
   output logic                                      readLatchEnable
);
   localparam int TIMER_PERIOD = USE_EXT_TICK ? EXT_TICK_COUNT : REFRESH_CYC;
   localparam int RAS_LIMIT    = RAS_MAX_CYC - dbc_pkg::RAS_GUARD_CYC;
   localparam int AGE_W        = $clog2(RAS_MAX_CYC + 1);

   // Address side
   logic [dbc_pkg::BUS_W-1:0] latchedAddr;
   wire  logic                dramSelect;
   wire  logic                bankPresent;
   wire  logic                accessReq;
   wire  dbc_pkg::dbc_req_t   newReq;
   wire  logic                pageHit;

   // Sequencer
   dbc_pkg::dbc_state_t       state;
   dbc_pkg::dbc_state_t       next_state;
   logic [3:0]                cnt;
   logic [3:0]                next_cnt;
   dbc_pkg::dbc_req_t         req;
   wire  dbc_pkg::dbc_req_t   next_req;
   wire  logic                acceptNew;
   logic                      bootRefresh;
   wire  logic                refreshReq;
   wire  logic                refreshAck;
   wire  logic                refreshDue;

   // Row-open age
   logic [AGE_W-1:0]          rasAge;
   wire  logic                anyRowLow;
   wire  logic                rasOld;

   // Strobe planning for the coming cycle
   wire  logic                rowHold;
   wire  logic                rowAll;
   wire  logic                colAccess;
   wire  logic                colAll;
   wire  logic                writePulse;
   wire  logic [dbc_pkg::MAX_BANKS-1:0] next_rowMask;
   wire  logic [dbc_pkg::MAX_BANKS-1:0] next_writeMask;
   wire  logic [dbc_pkg::NUM_LANES-1:0] next_colMask;

   // Demultiplex the shared bus; address holds until the next latch pulse
   always_ff @(posedge sys_clk) begin
      if (sys_rst) latchedAddr <= '0;
      else if (addrLatch) latchedAddr <= busAd;
   end

   // Only the bottom four megabytes belong to DRAM
   assign dramSelect = (latchedAddr[dbc_pkg::BUS_W-1:dbc_pkg::REGION_LSB] == '0);

   // Unpopulated banks never start a cycle
   assign bankPresent =
      (32'(latchedAddr[dbc_pkg::BANK_LSB +: dbc_pkg::BANK_W]) < NUM_BANKS);

   assign accessReq = dramSelect && bankPresent && (busRead || busWrite);

   // Bank from the two bits above each 1 MB block, word address below
   assign newReq.write = busWrite;
   assign newReq.bank  = latchedAddr[dbc_pkg::BANK_LSB +: dbc_pkg::BANK_W];
   assign newReq.row   = latchedAddr[dbc_pkg::ROW_LSB +: dbc_pkg::DEV_ADDR_W];
   assign newReq.col   = latchedAddr[dbc_pkg::COL_LSB +: dbc_pkg::DEV_ADDR_W];
   // Full word on reads saves lane logic on the read path
   assign newReq.lanes = busWrite ? byteEnable : dbc_pkg::ALL_LANES;

   // Page hit needs the processor hint and a matching open row
   assign pageHit = busWrite && writeNear
                    && (newReq.bank == req.bank)
                    && (newReq.row == req.row);

   // Refresh request generation
   dbc_refresh_timer #(
      .PERIOD       (TIMER_PERIOD),
      .USE_EXT_TICK (USE_EXT_TICK)
   ) u_refresh_timer (
      .sys_clk    (sys_clk),
      .sys_rst    (sys_rst),
      .extTick    (extRefreshTick),
      .refreshAck (refreshAck),
      .refreshReq (refreshReq)
   );

   assign refreshDue = refreshReq || bootRefresh;
   assign refreshAck = (state == dbc_pkg::ST_IDLE) && (next_state == dbc_pkg::ST_REF_CAS);

   // One refresh follows reset before any access is served
   always_ff @(posedge sys_clk) begin
      if (sys_rst) bootRefresh <= 1'b1;
      else if (refreshAck) bootRefresh <= 1'b0;
   end

   // Age of the current row-strobe low period
   assign anyRowLow = (rowStrobeBankN != '1);
   assign rasOld    = (32'(rasAge) >= RAS_LIMIT);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) rasAge <= '0;
      else if (!anyRowLow) rasAge <= '0;
      else if (!rasOld) rasAge <= rasAge + AGE_W'(1);
   end

   // Sequencer next state
   always_comb begin
      next_state = state;
      unique case (state)
         dbc_pkg::ST_IDLE: begin
            // Refresh first; a waiting bus cycle is taken afterwards
            if (refreshDue) begin
               next_state = dbc_pkg::ST_REF_CAS;
            end else if (accessReq) begin
               next_state = dbc_pkg::ST_ROW;
            end
         end
         dbc_pkg::ST_ROW: begin
            if (cnt == dbc_pkg::ROW_CYC - 4'h1) begin
               next_state = dbc_pkg::ST_COL;
            end
         end
         dbc_pkg::ST_COL: begin
            if (cnt == dbc_pkg::COL_CYC - 4'h1) begin
               next_state = dbc_pkg::ST_ACK;
            end
         end
         dbc_pkg::ST_ACK: begin
            next_state = dbc_pkg::ST_RELEASE;
         end
         dbc_pkg::ST_RELEASE: begin
            // Running bus cycle finishes before refresh gets in
            if (!busRead && !busWrite) begin
               next_state = req.write ? dbc_pkg::ST_OPEN : dbc_pkg::ST_PRE;
            end
         end
         dbc_pkg::ST_OPEN: begin
            // Old rows close in time even with no traffic
            if (refreshDue || rasOld) begin
               next_state = dbc_pkg::ST_PRE;
            end else if (accessReq && pageHit) begin
               next_state = dbc_pkg::ST_COL;
            end else if (accessReq) begin
               next_state = dbc_pkg::ST_PRE;
            end
         end
         dbc_pkg::ST_PRE: begin
            if (cnt == dbc_pkg::PRE_CYC - 4'h1) begin
               next_state = dbc_pkg::ST_IDLE;
            end
         end
         dbc_pkg::ST_REF_CAS: begin
            if (cnt == dbc_pkg::REF_CAS_CYC - 4'h1) begin
               next_state = dbc_pkg::ST_REF_RAS;
            end
         end
         dbc_pkg::ST_REF_RAS: begin
            if (cnt == dbc_pkg::REF_RAS_CYC - 4'h1) begin
               next_state = dbc_pkg::ST_PRE;
            end
         end
      endcase
   end

   // Phase counter restarts on every state change
   always_comb begin
      if (next_state != state) begin
         next_cnt = 4'h0;
      end else if (cnt == 4'hF) begin
         next_cnt = cnt;
      end else begin
         next_cnt = cnt + 4'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= dbc_pkg::ST_IDLE;
         cnt   <= 4'h0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // Capture the request as it is taken, fresh or page hit
   assign acceptNew = ((state == dbc_pkg::ST_IDLE) && (next_state == dbc_pkg::ST_ROW))
                      || ((state == dbc_pkg::ST_OPEN) && (next_state == dbc_pkg::ST_COL));
   assign next_req  = acceptNew ? newReq : req;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) req <= '0;
      else req <= next_req;
   end

   // Row strobe held from row phase through idle-open
   assign rowHold = (next_state == dbc_pkg::ST_ROW)
                    || (next_state == dbc_pkg::ST_COL)
                    || (next_state == dbc_pkg::ST_ACK)
                    || (next_state == dbc_pkg::ST_RELEASE)
                    || (next_state == dbc_pkg::ST_OPEN);
   // Refresh pulls every bank's row strobe after the column strobes
   assign rowAll = (next_state == dbc_pkg::ST_REF_RAS);
   // Column strobe kept through ack so read data stays on the pins
   assign colAccess = (next_state == dbc_pkg::ST_COL)
                      || ((next_state == dbc_pkg::ST_ACK) && !next_req.write);
   assign colAll = (next_state == dbc_pkg::ST_REF_CAS)
                   || (next_state == dbc_pkg::ST_REF_RAS);
   // Write strobe stays high in refresh so the devices see a refresh
   assign writePulse = (next_state == dbc_pkg::ST_COL) && next_req.write;

   genvar b;
   generate
      for (b = 0; b < dbc_pkg::MAX_BANKS; b++) begin : g_bank
         // Bank strobes follow the one decoded bank; refresh pulls every row strobe
         assign next_rowMask[b] = (rowHold && (next_req.bank == dbc_pkg::BANK_W'(b)))
                                  || rowAll;
         assign next_writeMask[b] = writePulse
                                    && (next_req.bank == dbc_pkg::BANK_W'(b));
      end
   endgenerate

   genvar l;
   generate
      for (l = 0; l < dbc_pkg::NUM_LANES; l++) begin : g_lane
         // Lane strobe is common to all banks; bank choice rides on row strobe
         assign next_colMask[l] = (colAccess && next_req.lanes[l]) || colAll;
      end
   endgenerate

   // Strobe pins come straight from flops to keep them glitch free
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rowStrobeBankN    <= '1;
         bankWriteStrobeN  <= '1;
         columnStrobeLaneN <= '1;
      end else begin
         rowStrobeBankN    <= ~next_rowMask;
         bankWriteStrobeN  <= ~next_writeMask;
         columnStrobeLaneN <= ~next_colMask;
      end
   end

   // Shared device address: row half, then column half
   dbc_addr_mux #(
      .W (dbc_pkg::DEV_ADDR_W)
   ) u_addr_mux (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .rowAddr (next_req.row),
      .colAddr (next_req.col),
      .useCol  (colAccess),
      .memAddr (memAddr)
   );

   // Handshake back to the processor
   assign busAck          = (state == dbc_pkg::ST_ACK);
   assign readLatchEnable = (state == dbc_pkg::ST_ACK) && !req.write;
endmodule : dbc_bank_control

`default_nettype wire

// >>> hdl/dbc_pkg.sv
// Constants, types and states shared by the DRAM bank controller
// How it works
// - DRAM answers only in the lowest four megabytes of physical address space.
// - One to four populated banks, each of by-four 256k-deep devices.
// - Latched address bits 21 and 20 pick the target bank.
// - Separate read and write strobes tell reads from writes.
// - Each bank has its own row strobe; strobe n serves bank n.
// - Each bank has its own write strobe; strobe n serves bank n.
// - Any read or write drives the per-bank strobes of exactly one bank.
// - Each bank covers one contiguous one-megabyte range.
// - Reads may return the whole 32-bit word whatever the requested size.
// - Writes drive only column strobes of enabled byte lanes, lane n to n.
// - Each column strobe reaches its byte lane in all four banks.
// - A refresh timer raises a refresh request every 9.6 microseconds.
// - Refresh timer runs from the bus clock or a separate oscillator.
// - No row strobe stays low over 10 microseconds, idle open rows included.
// - Address and data share one bus; the address is latched apart.
// - All logic runs on the processor's bus clock output.
// - Device address is the latched address multiplexed onto shared lines.
// - An access starts on DRAM select with read or write strobe.
// - Refresh beats new requests but waits for a running bus cycle.
// - Refresh is done only column strobe before row strobe.
package dbc_pkg;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int REFRESH_NS     = 9600;
   localparam int REFRESH_CYC    = REFRESH_NS / CLK_PERIOD_NS;
   localparam int RAS_MAX_NS     = 10000;
   localparam int RAS_MAX_CYC    = RAS_MAX_NS / CLK_PERIOD_NS;
   localparam int RAS_GUARD_CYC  = 16;
   // Oscillator ticks per refresh when the timer runs off a separate clock
   localparam int EXT_TICK_COUNT = 96;

   localparam int MAX_BANKS  = 4;
   localparam int NUM_LANES  = 4;
   localparam int BUS_W      = 32;
   localparam int DEV_ADDR_W = 9;
   localparam int REGION_LSB = 22;
   localparam int BANK_LSB   = 20;
   localparam int BANK_W     = 2;
   localparam int ROW_LSB    = 11;
   localparam int COL_LSB    = 2;

   localparam logic [3:0] ROW_CYC     = 4'h2;
   localparam logic [3:0] COL_CYC     = 4'h3;
   localparam logic [3:0] PRE_CYC     = 4'h2;
   localparam logic [3:0] REF_CAS_CYC = 4'h1;
   localparam logic [3:0] REF_RAS_CYC = 4'h4;
   localparam logic [3:0] ALL_LANES   = 4'hF;

   typedef struct packed {
      logic                  write;
      logic [BANK_W-1:0]     bank;
      logic [DEV_ADDR_W-1:0] row;
      logic [DEV_ADDR_W-1:0] col;
      logic [NUM_LANES-1:0]  lanes;
   } dbc_req_t;

   typedef enum {
      ST_IDLE,
      ST_ROW,
      ST_COL,
      ST_ACK,
      ST_RELEASE,
      ST_OPEN,
      ST_PRE,
      ST_REF_CAS,
      ST_REF_RAS
   } dbc_state_t;
endpackage : dbc_pkg

// >>> hdl/dbc_refresh_timer.sv
// Periodic refresh request with sticky pending flag
`timescale 1ns/10ps
`default_nettype none

module dbc_refresh_timer #(
   parameter int PERIOD       = dbc_pkg::REFRESH_CYC,
   parameter bit USE_EXT_TICK = 1'b0
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic extTick,
   input  wire logic refreshAck,
   output logic      refreshReq
);
   localparam int CW = $clog2(PERIOD + 1);

   logic [CW-1:0] count;
   logic [2:0]    tickSync;
   wire  logic    tickEn;
   wire  logic    wrap;

   // Oscillator edge seen only after two flops
   always_ff @(posedge sys_clk) begin
      if (sys_rst) tickSync <= 3'h0;
      else tickSync <= {tickSync[1:0], extTick};
   end

   assign tickEn = USE_EXT_TICK ? (tickSync[1] && !tickSync[2]) : 1'b1;
   assign wrap   = tickEn && (count == CW'(PERIOD - 1));

   always_ff @(posedge sys_clk) begin
      if (sys_rst) count <= '0;
      else if (wrap) count <= '0;
      else if (tickEn) count <= count + CW'(1);
   end

   // New request wins over a same-cycle acknowledge
   always_ff @(posedge sys_clk) begin
      if (sys_rst) refreshReq <= 1'b0;
      else if (wrap) refreshReq <= 1'b1;
      else if (refreshAck) refreshReq <= 1'b0;
   end
endmodule : dbc_refresh_timer

`default_nettype wire

// >>> hdl/dbc_addr_mux.sv
// Registered row/column multiplexer for the shared device address lines
`timescale 1ns/10ps
`default_nettype none

module dbc_addr_mux #(
   parameter int W = dbc_pkg::DEV_ADDR_W
) (
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] rowAddr,
   input  wire logic [W-1:0] colAddr,
   input  wire logic         useCol,
   output logic      [W-1:0] memAddr
);
   wire logic [W-1:0] next_memAddr;

   assign next_memAddr = useCol ? colAddr : rowAddr;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) memAddr <= '0;
      else memAddr <= next_memAddr;
   end
endmodule : dbc_addr_mux

`default_nettype wire

// >>> verif/dbc_bank_control_monitor.sv
// Port-level assertions for the DRAM bank controller
`timescale 1ns/10ps
`default_nettype none
module dbc_bank_control_monitor #(
   parameter int REFRESH_CYC = dbc_pkg::REFRESH_CYC,
   parameter int RAS_MAX_CYC = dbc_pkg::RAS_MAX_CYC
) (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [31:0] busAd,
   input wire logic        addrLatch,
   input wire logic        busRead,
   input wire logic        busWrite,
   input wire logic        writeNear,
   input wire logic [3:0]  byteEnable,
   input wire logic        extRefreshTick,
   input wire logic [3:0]  rowStrobeBankN,
   input wire logic [3:0]  bankWriteStrobeN,
   input wire logic [3:0]  columnStrobeLaneN,
   input wire logic [8:0]  memAddr,
   input wire logic        busAck,
   input wire logic        readLatchEnable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   int rasAge;
   int refAge;
   // Refresh starts when column strobes drop with every row strobe high
   wire refStart = columnStrobeLaneN != 4'hF && rowStrobeBankN == 4'hF;
   always_ff @(posedge sys_clk) begin
      rasAge <= (sys_rst || rowStrobeBankN == 4'hF) ? 0 : rasAge + 1;
      refAge <= (sys_rst || refStart) ? 0 : refAge + 1;
   end
   // Slack covers a bus cycle that runs ahead of a due refresh
   property p_ref_period; refAge <= REFRESH_CYC + 24; endproperty
   a_ref_period: assert property (p_ref_period) else $error("refresh overdue");
   property p_ras_max; rasAge < RAS_MAX_CYC; endproperty
   a_ras_max: assert property (p_ras_max) else $error("row strobe low too long");
   property p_one_row; rowStrobeBankN == 4'h0 || $onehot0(~rowStrobeBankN); endproperty
   a_one_row: assert property (p_one_row) else $error("several banks opened");
   property p_we_bank;
      $onehot0(~bankWriteStrobeN) && (~bankWriteStrobeN & rowStrobeBankN) == 4'h0;
   endproperty
   a_we_bank: assert property (p_we_bank) else $error("write strobe off its bank");
   property p_cbr;
      (rowStrobeBankN == 4'h0 && $past(rowStrobeBankN) != 4'h0)
         |-> $past(columnStrobeLaneN) == 4'h0 && bankWriteStrobeN == 4'hF;
   endproperty
   a_cbr: assert property (p_cbr) else $error("refresh not column first");
   property p_lanes; bankWriteStrobeN != 4'hF |-> columnStrobeLaneN == ~byteEnable; endproperty
   a_lanes: assert property (p_lanes) else $error("write lanes wrong");
   property p_read_word;
      readLatchEnable |-> busAck && busRead && columnStrobeLaneN == 4'h0;
   endproperty
   a_read_word: assert property (p_read_word) else $error("read not full word");
   property p_ack; busAck |-> (busRead || busWrite) ##1 !busAck; endproperty
   a_ack: assert property (p_ack) else $error("ack without strobe or too long");
   property p_start;
      ($past(rowStrobeBankN) == 4'hF && rowStrobeBankN != 4'hF && rowStrobeBankN != 4'h0)
         |-> $past(busRead || busWrite);
   endproperty
   a_start: assert property (p_start) else $error("row opened without request");
endmodule : dbc_bank_control_monitor
bind dbc_bank_control dbc_bank_control_monitor #(
   .REFRESH_CYC(REFRESH_CYC),
   .RAS_MAX_CYC(RAS_MAX_CYC)
) mon_u (.sys_clk, .sys_rst, .busAd, .addrLatch, .busRead, .busWrite, .writeNear,
   .byteEnable, .extRefreshTick, .rowStrobeBankN, .bankWriteStrobeN,
   .columnStrobeLaneN, .memAddr, .busAck, .readLatchEnable);
`default_nettype wire

// >>> verif/dbc_dram_model.sv
// Behavioural DRAM array recording row, column and refresh activity
`timescale 1ns/10ps
`default_nettype none
module dbc_dram_model (
   input  wire logic       sys_clk,
   input  wire logic [3:0] rowStrobeBankN,
   input  wire logic [3:0] bankWriteStrobeN,
   input  wire logic [3:0] columnStrobeLaneN,
   input  wire logic [8:0] memAddr,
   output logic      [1:0] lastBank,
   output logic      [8:0] lastRow,
   output logic      [8:0] lastCol,
   output logic      [3:0] lastLanes,
   output logic            lastWrite,
   output logic      [7:0] refreshCnt
);
   logic [3:0] prevRow = 4'hF;
   logic [3:0] prevCol = 4'hF;
   logic [7:0] refs = 8'h00;
   assign refreshCnt = refs;
   // Sampled mid-cycle so registered strobes and address have settled
   always @(negedge sys_clk) begin
      if (prevRow == 4'hF && $onehot(~rowStrobeBankN)) begin
         lastRow <= memAddr;
         for (int b = 0; b < 4; b++) if (!rowStrobeBankN[b]) lastBank <= 2'(b);
      end
      if (prevCol == 4'hF && columnStrobeLaneN != 4'hF) begin
         if (rowStrobeBankN == 4'hF) refs <= refs + 8'h01;
         else begin
            lastCol   <= memAddr;
            lastLanes <= ~columnStrobeLaneN;
            lastWrite <= bankWriteStrobeN != 4'hF;
         end
      end
      prevRow <= rowStrobeBankN;
      prevCol <= columnStrobeLaneN;
   end
endmodule : dbc_dram_model
`default_nettype wire

// >>> verif/dbc_bank_control_bench.sv
// Self-checking bench for the DRAM bank controller
`timescale 1ns/10ps
`default_nettype none
module dbc_bank_control_bench;
   localparam int REF_CYC   = 200;
   localparam int EXT_TICKS = 20;
   localparam int TICK_HALF = 37;
   // Fewest oscillator-timed refreshes that fit the idle window
   localparam int EXT_LO    = 3 * REF_CYC * dbc_pkg::CLK_PERIOD_NS / (EXT_TICKS * 2 * TICK_HALF);
   typedef struct packed {
      logic [31:0] addr;
      logic        wr;
      logic [3:0]  be;
      logic        ack;
   } dbc_case_t;
   logic        sys_clk = 1'b0, sys_rst = 1'b1, addrLatch = 1'b0, busRead = 1'b0;
   logic        busWrite = 1'b0, writeNear = 1'b0, busAck, readLatchEnable, lastWrite;
   logic [31:0] busAd = 32'h0000_0000;
   logic [3:0]  byteEnable = 4'h0, rowStrobeBankN, bankWriteStrobeN, columnStrobeLaneN;
   logic [3:0]  lastLanes;
   logic [8:0]  memAddr, lastRow, lastCol;
   logic [1:0]  lastBank;
   logic [7:0]  refreshCnt;
   int          error_cnt = 0, tests_run = 0;
   logic        ackRead, extTick = 1'b0;
   logic [3:0]  extColN, extColPrev = 4'hF;
   int          extRefs = 0;
   dbc_case_t   cases [6] = '{
      '{32'h0010_0804, 1'b0, 4'hF, 1'b1}, '{32'h0000_0000, 1'b1, 4'h3, 1'b1},
      '{32'h0030_0FFC, 1'b1, 4'h8, 1'b1}, '{32'h003F_FFFC, 1'b0, 4'hF, 1'b1},
      '{32'h0040_0000, 1'b0, 4'hF, 1'b0}, '{32'h0020_1000, 1'b1, 4'h5, 1'b1}};
   initial forever #5 sys_clk = ~sys_clk;
   // Row guard set below the refresh period so idle open rows close on it
   dbc_bank_control #(.REFRESH_CYC(REF_CYC), .RAS_MAX_CYC(REF_CYC - 60)) dut_u (
      .sys_clk, .sys_rst, .busAd, .addrLatch, .busRead, .busWrite, .writeNear,
      .byteEnable, .extRefreshTick(1'b0), .rowStrobeBankN, .bankWriteStrobeN,
      .columnStrobeLaneN, .memAddr, .busAck, .readLatchEnable);
   dbc_dram_model mem_u (.sys_clk, .rowStrobeBankN, .bankWriteStrobeN,
      .columnStrobeLaneN, .memAddr, .lastBank, .lastRow, .lastCol, .lastLanes,
      .lastWrite, .refreshCnt);
   // Second copy idles with its refresh timer on a free-running oscillator
   initial forever #(TICK_HALF) extTick = ~extTick;
   dbc_bank_control #(.REFRESH_CYC(REF_CYC), .RAS_MAX_CYC(REF_CYC - 60), .USE_EXT_TICK(1'b1),
      .EXT_TICK_COUNT(EXT_TICKS)) ext_u (
      .sys_clk, .sys_rst, .busAd(32'h0000_0000), .addrLatch(1'b0), .busRead(1'b0),
      .busWrite(1'b0), .writeNear(1'b0), .byteEnable(4'h0), .extRefreshTick(extTick),
      .rowStrobeBankN(), .bankWriteStrobeN(), .columnStrobeLaneN(extColN), .memAddr(),
      .busAck(), .readLatchEnable());
   always @(negedge sys_clk) begin
      extColPrev <= extColN;
      if (extColPrev == 4'hF && extColN == 4'h0) extRefs <= extRefs + 1;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (exp !== got) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check
   // Address phase then held strobes; the bus shows inverted data afterwards
   task automatic access(input logic [31:0] a, input logic wr, input logic [3:0] be,
                         input logic near, output int lat);
      @(negedge sys_clk);
      busAd = a;
      addrLatch = 1'b1;
      @(negedge sys_clk);
      addrLatch = 1'b0;
      busAd = ~a;
      busRead = !wr;
      busWrite = wr;
      byteEnable = be;
      writeNear = near;
      lat = -1;
      for (int n = 1; n <= 40 && lat < 0; n++) begin
         @(negedge sys_clk);
         if (busAck === 1'b1) begin
            lat = n;
            ackRead = readLatchEnable;
         end
      end
      if (lat > 0) @(negedge sys_clk);
      busRead = 1'b0;
      busWrite = 1'b0;
      writeNear = 1'b0;
      repeat (4) @(negedge sys_clk);
   endtask : access
   task automatic wait_refresh(input int limit);
      logic [7:0] r0;
      r0 = refreshCnt;
      for (int n = 0; n < limit && refreshCnt === r0; n++) @(negedge sys_clk);
      if (refreshCnt === r0) begin
         error_cnt++;
         $display("unexpected refresh wait timeout");
         end_sim();
      end
   endtask : wait_refresh
   initial begin
      int lat, e1;
      logic [7:0] r1;
      repeat (6) @(negedge sys_clk);
      check("row strobes in reset", 4'hF, rowStrobeBankN);
      check("column strobes in reset", 4'hF, columnStrobeLaneN);
      sys_rst = 1'b0;
      wait_refresh(20);
      $display("test reset done");
      foreach (cases[i]) begin
         access(cases[i].addr, cases[i].wr, cases[i].be, 1'b0, lat);
         if (cases[i].ack && lat < 0) begin
            error_cnt++;
            $display("unexpected ack timeout");
            end_sim();
         end
         check("ack", cases[i].ack, lat > 0);
         if (cases[i].ack) begin
            check("bank", cases[i].addr[21:20], lastBank);
            check("row", cases[i].addr[19:11], lastRow);
            check("col", cases[i].addr[10:2], lastCol);
            check("lanes", cases[i].wr ? cases[i].be : 4'hF, lastLanes);
            check("write", cases[i].wr, lastWrite);
            check("read latch", !cases[i].wr, ackRead);
         end
      end
      $display("test table done");
      // Align to a fresh refresh so it cannot fall inside the page pair
      wait_refresh(3 * REF_CYC);
      access(32'h0010_2000, 1'b1, 4'hF, 1'b0, lat);
      access(32'h0010_2004, 1'b1, 4'h2, 1'b1, lat);
      check("page latency", dbc_pkg::COL_CYC + 4'h1, lat);
      check("page row kept", 9'h004, lastRow);
      check("page col", 9'h001, lastCol);
      check("page lanes", 4'h2, lastLanes);
      $display("test page write done");
      r1 = refreshCnt;
      e1 = extRefs;
      // Guard closes the open row before the next refresh is due
      repeat (REF_CYC - 40) @(negedge sys_clk);
      check("open row closed", 4'hF, rowStrobeBankN);
      repeat (2 * REF_CYC + 40) @(negedge sys_clk);
      check("refreshes while open", 1, refreshCnt - r1 >= 8'h02);
      check("ext refreshes", 1, extRefs - e1 >= EXT_LO && extRefs - e1 <= EXT_LO + 1);
      $display("test idle open done");
      access(32'h0020_0000, 1'b1, 4'hF, 1'b0, lat);
      check("fresh latency", dbc_pkg::ROW_CYC + dbc_pkg::COL_CYC + 4'h1, lat);
      sys_rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      check("rows after mid reset", 4'hF, rowStrobeBankN);
      r1 = refreshCnt;
      sys_rst = 1'b0;
      repeat (12) @(negedge sys_clk);
      check("boot refresh", r1 + 8'h01, refreshCnt);
      $display("test mid reset done");
      end_sim();
   end
endmodule : dbc_bank_control_bench
`default_nettype wire
